// ==== logic/rxafc_map.vh ====
`ifndef RXAFC_MAP_VH
`define RXAFC_MAP_VH
`define RXAFC_CFG_OFFSET     8'hac
`define RXAFC_CFG_RESET      32'h0000_0000
`define RXAFC_CFG_WMASK      32'h00ff_ffff
`define RXAFC_HI_MSB         23
`define RXAFC_HI_LSB         16
`define RXAFC_LO_MSB         15
`define RXAFC_LO_LSB         8
`define RXAFC_DUR_MSB        7
`define RXAFC_DUR_LSB        4
`define RXAFC_BIT_MCAST      3
`define RXAFC_BIT_BCAST      2
`define RXAFC_BIT_OWN        1
`define RXAFC_BIT_ANY        0
`define RXAFC_UNIT_SHIFT     6
`define RXAFC_CLK_MHZ        100
`define RXAFC_SLOW_EXTRA_NS  2200
`define RXAFC_NS_PER_CYCLE   10
`endif

// ==== logic/rxafc_sync.v ====
`timescale 1ns/1ps
// three-stage pin synchroniser; a change counts once stages two and three agree
module rxafc_sync (
  input  wire clock_i,
  input  wire rst_b_i,
  input  wire pin_i,
  output reg  level_o
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1      <= 1'b0;
      s2      <= 1'b0;
      s3      <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end
endmodule // rxafc_sync

// ==== logic/rxafc_jam_timer.v ====
`timescale 1ns/1ps
`include "rxafc_map.vh"
// backpressure period timer: duration code to cycle count, counts down
module rxafc_jam_timer #(
  parameter CNT_W = 17
) (
  input  wire       clock_i,
  input  wire       rst_b_i,
  input  wire       start_i,
  input  wire [3:0] code_i,
  input  wire       slow_i,
  input  wire       abort_i,
  output wire       busy_o
);
  reg [CNT_W-1:0] count;

  function [CNT_W-1:0] dur_cycles;
    input [3:0] code;
    input       slow;
    reg   [31:0] us;
    reg   [31:0] cyc;
    begin
      case (code)
        4'h0: us = 32'd5;
        4'h1: us = 32'd10;
        4'h2: us = 32'd15;
        4'h3: us = 32'd25;
        4'h4: us = 32'd50;
        default: us = (code - 32'd3) * 32'd50;
      endcase
      cyc = us * `RXAFC_CLK_MHZ;
      if (slow) begin
        cyc = cyc + `RXAFC_SLOW_EXTRA_NS / `RXAFC_NS_PER_CYCLE;
      end
      dur_cycles = cyc[CNT_W-1:0];
    end
  endfunction

  assign busy_o = (count != {CNT_W{1'b0}});

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= {CNT_W{1'b0}};
    end else if (abort_i) begin
      count <= {CNT_W{1'b0}};
    end else if (start_i) begin
      count <= dur_cycles(code_i, slow_i); // (R12)
    end else if (busy_o) begin
      count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
endmodule // rxafc_jam_timer

// ==== logic/rxafc_top.v ====
`timescale 1ns/1ps
`include "rxafc_map.vh"
// Contract
// (R1) no pause frame and no backpressure while the transmitter is disabled
// (R2) high level is bits 23:16 in 64-byte units; flow control starts there
// (R3) full duplex: one pause frame with the programmed pause time at high level
// (R4) half duplex: jam each selected incoming frame for the programmed duration
// (R5) low level is bits 15:8; falling below it sends a zero-time pause
// (R6) zero-time pause only after high was reached and a pause was sent
// (R7) software keeps low level strictly below high level when enabled
// (R8) bits 7:4 select backpressure duration; unused in full duplex
// (R9) bit 3 jams multicast frames in half duplex above high level
// (R10) bit 2 jams broadcast frames in half duplex above high level
// (R11) bit 1 jams frames to own address in half duplex above high level
// (R12) duration codes map 5 to 600 us, 2.2 us more at 10 Mb/s
// (R13) bit 0 acts on any frame, overrides bits 3:1, pauses without decode
// (R14) compare fifo byte count to each level times 64 every cycle
module rxafc_top #(
  parameter FIFO_W  = 14,
  parameter PAUSE_W = 16,
  parameter JAM_W   = 17
) (
  input  wire               clock_i,
  input  wire               rst_b_i,
  input  wire               reg_wr_i,
  input  wire               reg_rd_i,
  input  wire [7:0]         reg_addr_i,
  input  wire [31:0]        reg_wdata_i,
  output reg  [31:0]        reg_rdata_o,
  input  wire [FIFO_W-1:0]  rx_fifo_used_i,
  input  wire               tx_enable_i,
  input  wire               full_duplex_i,
  input  wire               speed_10_i,
  input  wire [PAUSE_W-1:0] pause_time_value_i,
  input  wire               rx_preamble_i,
  input  wire               rx_addr_valid_i,
  input  wire               rx_is_multicast_i,
  input  wire               rx_is_broadcast_i,
  input  wire               rx_is_own_addr_i,
  input  wire               pause_done_i,
  output reg                pause_req_o,
  output reg  [PAUSE_W-1:0] pause_time_o,
  output reg                backpressure_o,
  output reg                above_high_o
);
  localparam ST_IDLE   = 2'd0;
  localparam ST_SEND   = 2'd1;
  localparam ST_PAUSED = 2'd2;
  localparam ST_RESUME = 2'd3;

  reg  [31:0]        cfg;
  reg  [1:0]         state;
  reg  [1:0]         next_state;
  reg                next_pause_req;
  reg  [PAUSE_W-1:0] next_pause_time;
  reg                sent_flag;
  reg                next_sent_flag;
  reg                jam_start;
  reg                hi_pending;
  wire               tx_en_s;
  wire               jam_busy;
  wire [7:0]         hi_lvl = cfg[`RXAFC_HI_MSB:`RXAFC_HI_LSB];
  wire [7:0]         lo_lvl = cfg[`RXAFC_LO_MSB:`RXAFC_LO_LSB];
  wire [3:0]         dur    = cfg[`RXAFC_DUR_MSB:`RXAFC_DUR_LSB];
  wire               any_en = cfg[`RXAFC_BIT_ANY];
  wire               afc_en = |cfg[`RXAFC_BIT_MCAST:`RXAFC_BIT_ANY];
  wire [FIFO_W+7:0]  used_w = {8'h00, rx_fifo_used_i};
  wire [FIFO_W+7:0]  hi_b   = {{FIFO_W{1'b0}}, hi_lvl} << `RXAFC_UNIT_SHIFT; // (R14)
  wire [FIFO_W+7:0]  lo_b   = {{FIFO_W{1'b0}}, lo_lvl} << `RXAFC_UNIT_SHIFT; // (R14)
  wire               at_high = (used_w >= hi_b); // (R2)
  wire               below_low = (used_w < lo_b); // (R5)

  // tx enable may come from the mac's own domain, so it is synchronised
  rxafc_sync u_txen (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .pin_i   (tx_enable_i),
    .level_o (tx_en_s)
  );

  rxafc_jam_timer #(
    .CNT_W (JAM_W)
  ) u_jam (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .start_i (jam_start),
    .code_i  (dur),
    .slow_i  (speed_10_i),
    .abort_i (!tx_en_s || full_duplex_i), // (R1) (R8)
    .busy_o  (jam_busy)
  );

  // register access: reserved top byte reads zero and ignores writes
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg <= `RXAFC_CFG_RESET;
    end else if (reg_wr_i && reg_addr_i == `RXAFC_CFG_OFFSET) begin
      cfg <= reg_wdata_i & `RXAFC_CFG_WMASK;
    end
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i && reg_addr_i == `RXAFC_CFG_OFFSET) begin
      reg_rdata_o <= cfg;
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // half duplex frame selection; bit 0 overrides the per-type bits
  function frame_hit;
    input any;
    input [2:0] sel;
    input pre;
    input dec;
    input mc;
    input bc;
    input own;
    begin
      if (any) begin
        frame_hit = pre; // (R13)
      end else begin
        frame_hit = dec && ((sel[2] && mc) || (sel[1] && bc) || (sel[0] && own)); // (R9) (R10) (R11)
      end
    end
  endfunction

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      jam_start      <= 1'b0;
      backpressure_o <= 1'b0;
      above_high_o   <= 1'b0;
    end else begin
      above_high_o <= at_high;
      jam_start    <= tx_en_s && !full_duplex_i && at_high && !jam_busy && // (R4)
                      frame_hit(any_en, cfg[`RXAFC_BIT_MCAST:`RXAFC_BIT_OWN],
                                rx_preamble_i, rx_addr_valid_i, rx_is_multicast_i,
                                rx_is_broadcast_i, rx_is_own_addr_i);
      // follows the timer, gated only by tx enable and half duplex, so the jam lasts exactly the coded number of cycles
      backpressure_o <= tx_en_s && !full_duplex_i && jam_busy; // (R1) (R4)
    end
  end

  // full duplex: the high-level pause requires bit 0; the zero-time pause needs any of bits 3:0
  always @* begin
    next_state      = state;
    next_pause_req  = pause_req_o;
    next_pause_time = pause_time_o;
    next_sent_flag  = sent_flag;
    hi_pending      = full_duplex_i && any_en && at_high;
    case (state)
      ST_IDLE: begin
        if (tx_en_s && hi_pending) begin // (R3)
          next_state      = ST_SEND;
          next_pause_req  = 1'b1;
          next_pause_time = pause_time_value_i; // (R3)
        end
      end
      ST_SEND: begin
        if (pause_done_i) begin
          next_pause_req = 1'b0;
          next_sent_flag = 1'b1; // (R6)
          next_state     = ST_PAUSED;
        end
      end
      ST_PAUSED: begin
        // only one pause while above high; resume once below low
        if (sent_flag && below_low && afc_en) begin // (R5) (R6)
          next_state      = ST_RESUME;
          next_pause_req  = 1'b1;
          next_pause_time = {PAUSE_W{1'b0}}; // (R5)
        end
      end
      ST_RESUME: begin
        if (pause_done_i) begin
          next_pause_req = 1'b0;
          next_sent_flag = 1'b0;
          next_state     = ST_IDLE;
        end
      end
      default: begin
        next_state     = ST_IDLE;
        next_pause_req = 1'b0;
      end
    endcase
    if (!tx_en_s || !full_duplex_i) begin // (R1)
      next_state     = ST_IDLE;
      next_pause_req = 1'b0;
      next_sent_flag = 1'b0;
    end
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state        <= ST_IDLE;
      pause_req_o  <= 1'b0;
      pause_time_o <= {PAUSE_W{1'b0}};
      sent_flag    <= 1'b0;
    end else begin
      state        <= next_state;
      pause_req_o  <= next_pause_req;
      pause_time_o <= next_pause_time;
      sent_flag    <= next_sent_flag;
    end
  end
endmodule // rxafc_top

// ==== test/rxafc_checker.sv ====
`timescale 1ns/1ps
module rxafc_checker #(
  parameter FIFO_W  = 14,
  parameter PAUSE_W = 16
) (
  input wire               clock_i,
  input wire               rst_b_i,
  input wire               reg_wr_i,
  input wire               reg_rd_i,
  input wire [7:0]         reg_addr_i,
  input wire [31:0]        reg_wdata_i,
  input wire [31:0]        reg_rdata_o,
  input wire [FIFO_W-1:0]  rx_fifo_used_i,
  input wire               tx_enable_i,
  input wire               full_duplex_i,
  input wire               speed_10_i,
  input wire [PAUSE_W-1:0] pause_time_value_i,
  input wire               pause_done_i,
  input wire               pause_req_o,
  input wire [PAUSE_W-1:0] pause_time_o,
  input wire               backpressure_o,
  input wire               above_high_o
);
  reg [31:0] cfg;
  reg [15:0] bp_cnt;
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg    <= 32'h0;
      bp_cnt <= 16'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == 8'hac)
        cfg <= reg_wdata_i & 32'h00ff_ffff;
      bp_cnt <= backpressure_o ? bp_cnt + 16'h1 : 16'h0;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // the transmitter enable passes a synchroniser, so allow it time to settle
  chk_tx_off_quiet: assert property ((!tx_enable_i) [*8] |-> !pause_req_o && !backpressure_o)
    else $error("pause or jam with transmitter off");
  chk_high_compare: assert property ($past(rst_b_i) |->
    above_high_o == ($past(rx_fifo_used_i) >= {$past(cfg[23:16]), 6'h0}))
    else $error("high level compare wrong");
  chk_read_data: assert property (reg_rd_i |=>
    reg_rdata_o == ($past(reg_addr_i) == 8'hac ? $past(cfg) : 32'h0))
    else $error("read data wrong");
  chk_done_drops: assert property (pause_req_o && pause_done_i |=> !pause_req_o)
    else $error("pause request held after done");
  chk_pause_time: assert property ($rose(pause_req_o) && pause_time_o != 0 |->
    pause_time_o == $past(pause_time_value_i))
    else $error("pause time wrong");
  chk_zero_below: assert property ($rose(pause_req_o) && pause_time_o == 0 |->
    $past(rx_fifo_used_i) < {$past(cfg[15:8]), 6'h0})
    else $error("zero pause above low level");
  chk_jam_length: assert property ($fell(backpressure_o) && tx_enable_i && !full_duplex_i
    && cfg[7:4] == 4'h0 |-> bp_cnt == (speed_10_i ? 16'h2d0 : 16'h1f4))
    else $error("jam length wrong");
  chk_fd_no_jam: assert property (full_duplex_i [*3] |-> !backpressure_o)
    else $error("jam in full duplex");
  cover property ($rose(pause_req_o) && pause_time_o != 0);
  cover property ($rose(pause_req_o) && pause_time_o == 0);
  cover property ($fell(backpressure_o));
endmodule // rxafc_checker
bind rxafc_top rxafc_checker #(.FIFO_W(FIFO_W), .PAUSE_W(PAUSE_W)) i_rxafc_checker (.*);

// ==== test/rxafc_mac_model.sv ====
`timescale 1ns/1ps
// mac transmitter: sends the requested pause frame delay_i+1 cycles after the request
module rxafc_mac_model (
  input  wire       clock_i,
  input  wire       rst_b_i,
  input  wire       pause_req_i,
  input  wire [3:0] delay_i,
  output reg        pause_done_o
);
  reg [3:0] wait_cnt;
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_cnt     <= 4'h0;
      pause_done_o <= 1'b0;
    end else begin
      pause_done_o <= 1'b0;
      // skip the cycle after done so one request yields one frame
      if (pause_req_i && !pause_done_o) begin
        wait_cnt <= (wait_cnt == delay_i) ? 4'h0 : wait_cnt + 4'h1;
        pause_done_o <= (wait_cnt == delay_i);
      end
    end
  end
endmodule // rxafc_mac_model

// ==== test/test_rx_automatic_flow_control.sv ====
`timescale 1ns/1ps
module test_rx_automatic_flow_control;
  reg        clock_i, rst_b_i, reg_wr_i, reg_rd_i, tx_enable_i, full_duplex_i, speed_10_i;
  reg        rx_preamble_i, rx_addr_valid_i, rx_is_multicast_i, rx_is_broadcast_i;
  reg        rx_is_own_addr_i, rd_d, req_d, bp_d;
  reg [7:0]  reg_addr_i;
  reg [31:0] reg_wdata_i, w;
  reg [13:0] rx_fifo_used_i;
  reg [15:0] pause_time_value_i, bp_len;
  reg [3:0]  mdelay;
  wire       pause_done_i, pause_req_o, backpressure_o, above_high_o;
  wire [31:0] reg_rdata_o;
  wire [15:0] pause_time_o;
  integer    num_errors, checked, cyc, i;
  reg [31:0] exp_q[$];
  rxafc_top i_rxafc_top (.*);
  rxafc_mac_model i_rxafc_mac_model (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .pause_req_i(pause_req_o), .delay_i(mdelay), .pause_done_o(pause_done_i));
  always #5 clock_i = ~clock_i;
  task chk(input [31:0] seen, input [31:0] exp, input [39:0] what);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("Error %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task pop(input [31:0] seen, input [39:0] what);
    if (exp_q.size() == 0)
      chk(32'h1, 32'h0, what);
    else
      chk(seen, exp_q.pop_front(), what);
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clock_i);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      reg_wr_i = 1; reg_addr_i = a; reg_wdata_i = d; tick(1);
      reg_wr_i = 0; tick(1);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      exp_q.push_back(e); reg_rd_i = 1; reg_addr_i = a; tick(1);
      reg_rd_i = 0; tick(1);
    end
  endtask
  task frame(input [3:0] f);
    begin
      rx_preamble_i = 1; tick(1);
      rx_preamble_i = 0; rx_addr_valid_i = 1;
      {rx_is_multicast_i, rx_is_broadcast_i, rx_is_own_addr_i} = f[3:1]; tick(1);
      rx_addr_valid_i = 0; tick(1);
    end
  endtask
  task drain;
    while (exp_q.size() != 0) tick(1);
  endtask
  always @(posedge clock_i) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
    if (rd_d) pop(reg_rdata_o, "read");
    if (pause_req_o && !req_d) pop({16'h0, pause_time_o}, "pause");
    if (bp_d && !backpressure_o) pop({16'h0, bp_len}, "jam");
    bp_len <= backpressure_o ? bp_len + 16'h1 : 16'h0;
    rd_d <= reg_rd_i; req_d <= pause_req_o; bp_d <= backpressure_o;
  end
  initial begin
    {clock_i, rst_b_i, reg_wr_i, reg_rd_i, full_duplex_i, speed_10_i, rd_d, req_d, bp_d} = 0;
    {rx_preamble_i, rx_addr_valid_i, rx_is_multicast_i, rx_is_broadcast_i} = 0;
    {rx_is_own_addr_i, reg_addr_i, reg_wdata_i, rx_fifo_used_i, bp_len, mdelay} = 0;
    tx_enable_i = 1; num_errors = 0; checked = 0; cyc = 0;
    w = $urandom(32'h1f41ca7c);
    pause_time_value_i = $urandom | 16'h1;
    tick(3); rst_b_i = 1; tick(5);
    w = $urandom; wr(8'hac, w); rd(8'hac, {8'h0, w[23:0]});
    wr(8'ha8, ~w); rd(8'ha8, 32'h0); rd(8'hac, {8'h0, w[23:0]}); drain;
    $display("test registers done");
    full_duplex_i = 1; rx_fifo_used_i = 14'h7f; wr(8'hac, 32'h0002_0101); tick(3);
    chk(above_high_o, 32'h0, "above");
    for (i = 0; i < 2; i = i + 1) begin
      mdelay = i ? 4'h9 : 4'h0;
      exp_q.push_back({16'h0, pause_time_value_i}); rx_fifo_used_i = 14'h80; drain;
      chk(above_high_o, 32'h1, "above");
      rx_fifo_used_i = 14'h40; tick(20);
      exp_q.push_back(32'h0); rx_fifo_used_i = 14'h3f; drain; tick(15);
    end
    rx_fifo_used_i = 14'h50; tick(5); rx_fifo_used_i = 14'h0; tick(20);
    tx_enable_i = 0; tick(10); rx_fifo_used_i = 14'h80; tick(30);
    rx_fifo_used_i = 14'h0; tick(5); tx_enable_i = 1; tick(10);
    $display("test pause done");
    full_duplex_i = 0; rx_fifo_used_i = 14'h80;
    for (i = 0; i < 4; i = i + 1) begin
      speed_10_i = $urandom;
      wr(8'hac, 32'h0002_0100 | (i[0] ? 32'h10 : 32'h0) | (32'h1 << i));
      if (i != 0) frame(4'he & ~(4'h1 << i));
      tick(5);
      exp_q.push_back((i[0] ? 32'h3e8 : 32'h1f4) + (speed_10_i ? 32'hdc : 32'h0));
      frame(4'h1 << i); drain; tick(3);
    end
    $display("test jam done");
    finish_test;
  end
endmodule // test_rx_automatic_flow_control
